// *** inc/sep_core_if.sv ***
`timescale 1ns/1ns
interface sep_core_if;
  sep_pkg::sep_byte_t rx_byte;
  logic tmr_start;
  logic tmr_busy;
  modport shf (output rx_byte);
  modport tmr (input tmr_start, output tmr_busy);
  modport core (input rx_byte, input tmr_busy, output tmr_start);
endinterface : sep_core_if

// *** inc/sep_map.svh ***
`ifndef SEP_MAP_SVH
`define SEP_MAP_SVH
// How it works
// - Write: word address follows device byte; address and data byte each acked low.
// - Stop ends write; self-timed cycle then runs, bus ignored meanwhile.
// - Protected write still acked fully; data dropped; full cycle time still runs.
// - Page write takes up to sixteen bytes, each acked, closed by stop.
// - Write increments only low four address bits; page wraps onto itself.
// - Polling: device byte acked only after the write cycle has ended.
// - Set flag blocks writes to 00H-7FH; protect pin blocks whole array.
// - Write with code 0110 and pin low sets the flag; address, data ignored.
// - Once flag set, 0110 device bytes never acked; flag kept across power.
// - Pin high: flag not set though 0110 write acked; all array writes blocked.
// - Pin low: flag set allows 80H-FFH only; flag clear allows all.
// - 0110 read acked with dummy data while flag clear; not acked once set.
// - Read uses read/write bit one; 1010 reads acked whatever the flag.
// - Address counter holds last address plus one across reads and writes.
// - Read past last byte wraps counter to address zero.
// - Current-address read sends byte at counter; controller nack plus stop ends.
// - Sequential read: each controller ack advances and sends next byte.
// - Device byte: 4-bit code, three select bits, read/write bit; ack ninth clock.
// - Select bits must match straps, else no ack and back to idle.
// - Array of 256 bytes, 16 pages of 16, 8-bit word address.
`define SEP_TWR_MS 5
`define SEP_CLK_HZ 20000000
`define SEP_HZ_PER_MS 1000
`define SEP_DEPTH 256
`define SEP_CODE_ARRAY 4'ha
`define SEP_CODE_PROT 4'h6
`define SEP_LOW_TOP 8'h7f
`define SEP_PROT_RD_DATA 8'hff
`define SEP_CNT_ONE 4'h1
`define SEP_BIT_MSB 4'h7
`define SEP_CNT_ACK 4'h8
`define SEP_CNT_END 4'h9
`define SEP_NPIN 6
`define SEP_PIN_SCL 0
`define SEP_PIN_SDA 1
`define SEP_PIN_WP 2
`define SEP_PIN_CS 3
`define SEP_PIN_IDLE 6'h03
`endif

// *** inc/sep_pkg.sv ***
package sep_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV = 6'h02,
    ST_WADR = 6'h04,
    ST_WDAT = 6'h08,
    ST_RACK = 6'h10,
    ST_RDAT = 6'h20
  } sep_state_t;
  typedef logic [7:0] sep_byte_t;
endpackage : sep_pkg

// *** verif/sep_bus_ctl.sv ***
`timescale 1ns/1ns
module sep_bus_ctl (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  logic lclk;
  // ----
  // Link tick, 125 ns; serial clock idles high
  // ----
  initial begin
    lclk = 1'b0;
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    #37;
    forever begin
      #62 lclk = 1'b1;
      #63 lclk = 1'b0;
    end
  end
  task automatic tk(input int n);
    repeat (n) @(posedge lclk);
  endtask : tk
  // Start or repeated start
  task automatic start();
    sda_low_o = 1'b0;
    tk(4);
    scl_o = 1'b1;
    tk(4);
    sda_low_o = 1'b1;
    tk(4);
    scl_o = 1'b0;
    tk(4);
  endtask : start
  task automatic stop();
    sda_low_o = 1'b1;
    tk(4);
    scl_o = 1'b1;
    tk(4);
    sda_low_o = 1'b0;
    tk(8);
  endtask : stop
  // One bit: drive o (1 releases), sample the wire
  task automatic bitx(input logic o, output logic b);
    sda_low_o = ~o;
    tk(4);
    scl_o = 1'b1;
    tk(4);
    b = sda_i;
    tk(4);
    scl_o = 1'b0;
    tk(4);
  endtask : bitx
  // Byte out, MSB first; ak is 1 when acked
  task automatic send(input logic [7:0] d, output logic [7:0] ak);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], b);
    end
    bitx(1'b1, b);
    ak = {7'h0, ~b};
  endtask : send
  // Byte in; more low ends a read without ack
  task automatic recv(input logic more, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, b);
      d[i] = b;
    end
    bitx(~more, b);
  endtask : recv
endmodule : sep_bus_ctl

// *** verif/test_serial_eeprom_access_protect.sv ***
`timescale 1ns/1ns
`include "sep_map.svh"
module test_serial_eeprom_access_protect;
  localparam int WRC = 2000;
  localparam logic [2:0] CS = 3'h5;
  localparam logic [3:0] CA = `SEP_CODE_ARRAY;
  localparam logic [3:0] CP = `SEP_CODE_PROT;
  logic mclk_i, rst_i, wp_i, prot_init_i;
  logic [2:0] straps;
  logic scl, sda_low, sda_oe, flag, busy;
  logic [7:0] rd_last;
  logic sda_zero;
  logic [7:0] none[$];
  wire sda_w;
  int fails = 0;
  int n_tests = 0;
  assign sda_w = ~(sda_low | sda_oe);
  sep_bus_ctl u_ctl (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));
  sep_eeprom_top #(.WR_CYCLES(WRC)) u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .scl_clk_i(scl), .sda_i(sda_w), .wp_i(wp_i),
    .chip_select_straps_i(straps), .prot_init_i(prot_init_i), .rd_last_o(rd_last), .sda_o(sda_zero),
    .sda_oe_o(sda_oe), .prot_flag_o(flag), .busy_o(busy)
  );
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // ----
  // Helpers
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("compares %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic clks(input int n);
    repeat (n) @(posedge mclk_i);
    #5;
  endtask : clks
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < WRC + 200) begin
      clks(1);
      k++;
    end
    if (k >= WRC + 200) begin
      fails++;
      $display("[FAIL] %0t write cycle never ended", $time);
      print_verdict();
    end
  endtask : wait_idle
  task automatic do_reset();
    clks(1);
    rst_i = 1'b1;
    clks(12);
    rst_i = 1'b0;
    clks(10);
  endtask : do_reset
  task automatic set_wp(input logic v);
    clks(1);
    wp_i = v;
    clks(10);
  endtask : set_wp
  // Write n bytes from d0 upward; tmd checks the timed cycle and polling
  task automatic wr(input logic [3:0] code, input logic [7:0] adr, input int n, input logic [7:0] d0,
                    input logic tmd);
    logic [7:0] ak;
    u_ctl.start();
    u_ctl.send({code, CS, 1'b0}, ak);
    check(ak, 8'h01, "device byte ack");
    u_ctl.send(adr, ak);
    check(ak, 8'h01, "word address ack");
    for (int i = 0; i < n; i++) begin
      u_ctl.send(d0 + 8'(i), ak);
      check(ak, 8'h01, "data ack");
    end
    u_ctl.stop();
    clks(10);
    if (tmd) begin
      check({7'h0, busy}, 8'h01, "cycle running");
      u_ctl.start();
      u_ctl.send({CA, CS, 1'b0}, ak);
      check(ak, 8'h00, "poll while busy");
      u_ctl.stop();
    end
    wait_idle();
    u_ctl.start();
    u_ctl.send({CA, CS, 1'b0}, ak);
    check(ak, 8'h01, "poll after cycle");
    u_ctl.stop();
  endtask : wr
  // Read exp.size() bytes; rnd loads adr by a dummy write first
  task automatic rd(input logic [3:0] code, input logic [7:0] adr, input logic rnd, input logic [7:0] eack,
                    input logic [7:0] exp[$]);
    logic [7:0] ak;
    logic [7:0] d;
    if (rnd) begin
      u_ctl.start();
      u_ctl.send({CA, CS, 1'b0}, ak);
      u_ctl.send(adr, ak);
    end
    u_ctl.start();
    u_ctl.send({code, CS, 1'b1}, ak);
    check(ak, eack, "read device byte ack");
    foreach (exp[i]) begin
      u_ctl.recv(i < exp.size() - 1, d);
      check(d, exp[i], "read data");
    end
    u_ctl.stop();
    if (exp.size() > 0) begin
      check(rd_last, exp[exp.size() - 1], "last byte out");
    end
  endtask : rd
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    check({7'h0, busy}, 8'h00, "busy after reset");
    check({7'h0, sda_oe}, 8'h00, "line free after reset");
    check({7'h0, sda_zero}, 8'h00, "open drain level low");
    check(rd_last, 8'h00, "last byte after reset");
    check({7'h0, flag}, 8'h00, "flag after reset");
    $display("test reset done");
  endtask : t_reset
  task automatic t_select();
    logic [7:0] ak;
    u_ctl.start();
    u_ctl.send({CA, ~CS, 1'b0}, ak);
    check(ak, 8'h00, "strap mismatch");
    u_ctl.stop();
    u_ctl.start();
    u_ctl.send({4'h3, CS, 1'b0}, ak);
    check(ak, 8'h00, "unknown code");
    u_ctl.stop();
    $display("test select done");
  endtask : t_select
  task automatic t_wrap();
    wr(CA, 8'h00, 1, 8'h3c, 1'b1);
    wr(CA, 8'hff, 1, 8'hc3, 1'b1);
    rd(CA, 8'hff, 1'b1, 8'h01, '{8'hc3});
    rd(CA, 8'h00, 1'b0, 8'h01, '{8'h3c});
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_page();
    logic [7:0] q[$];
    for (int k = 0; k < 14; k++) begin
      q.push_back(8'h42 + 8'(k));
    end
    q.push_back(8'h50);
    q.push_back(8'h41);
    wr(CA, 8'h2e, 17, 8'h40, 1'b1);
    rd(CA, 8'h20, 1'b1, 8'h01, q);
    $display("test page done");
  endtask : t_page
  task automatic t_protect();
    wr(CA, 8'h90, 1, 8'h11, 1'b1);
    set_wp(1'b1);
    wr(CA, 8'h90, 1, 8'h22, 1'b1);
    rd(CA, 8'h90, 1'b1, 8'h01, '{8'h11});
    rd(CP, 8'h00, 1'b0, 8'h01, '{`SEP_PROT_RD_DATA});
    wr(CP, 8'h00, 1, 8'h00, 1'b0);
    check({7'h0, flag}, 8'h00, "flag refused with pin high");
    set_wp(1'b0);
    wr(CP, 8'h5a, 1, 8'h00, 1'b1);
    check({7'h0, flag}, 8'h01, "flag set");
    rd(CP, 8'h00, 1'b0, 8'h00, none);
    wr(CA, 8'h00, 1, 8'h99, 1'b1);
    rd(CA, 8'h00, 1'b1, 8'h01, '{8'h3c});
    wr(CA, 8'h90, 1, 8'h33, 1'b1);
    set_wp(1'b1);
    rd(CA, 8'h90, 1'b1, 8'h01, '{8'h33});
    $display("test protect done");
  endtask : t_protect
  task automatic t_persist();
    clks(1);
    prot_init_i = 1'b1;
    do_reset();
    check({7'h0, flag}, 8'h01, "flag kept over reset");
    $display("test persist done");
  endtask : t_persist
  initial begin
    rst_i = 1'b1;
    wp_i = 1'b0;
    prot_init_i = 1'b0;
    straps = CS;
    do_reset();
    t_reset();
    t_select();
    t_wrap();
    t_page();
    t_protect();
    t_persist();
    print_verdict();
  end
endmodule : test_serial_eeprom_access_protect

// *** verilog/sep_bit_shift.sv ***
`timescale 1ns/1ns
module sep_bit_shift (
  input wire logic scl_clk_i,
  input wire logic sda_i,
  sep_core_if.shf lnk
);
  import sep_pkg::*;
  sep_byte_t sh_reg;
  // ----------------------------------------
  // Bit capture on the link clock
  // ----------------------------------------
  always_ff @(posedge scl_clk_i) begin
    sh_reg <= {sh_reg[6:0], sda_i};
  end
  assign lnk.rx_byte = sh_reg;
endmodule : sep_bit_shift

// *** verilog/sep_eeprom_top.sv ***
`timescale 1ns/1ns
`include "sep_map.svh"
module sep_eeprom_top #(
  parameter int WR_CYCLES = `SEP_TWR_MS * (`SEP_CLK_HZ / `SEP_HZ_PER_MS)
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_clk_i,
  input wire logic sda_i,
  input wire logic wp_i,
  input wire logic [2:0] chip_select_straps_i,
  input wire logic prot_init_i,
  output sep_pkg::sep_byte_t rd_last_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic prot_flag_o,
  output logic busy_o
);
  import sep_pkg::*;

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  sep_core_if cif ();

  sep_bit_shift u_shift (
    .scl_clk_i(scl_clk_i),
    .sda_i(sda_i),
    .lnk(cif.shf)
  );

  sep_wr_timer #(
    .WR_CYCLES(WR_CYCLES)
  ) u_tmr (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .tmr(cif.tmr)
  );

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NPIN = `SEP_NPIN;
  localparam logic [NPIN-1:0] PIN_IDLE = `SEP_PIN_IDLE;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] ff1_reg;
  logic [NPIN-1:0] ff2_reg;
  logic [NPIN-1:0] ff3_reg;
  logic [NPIN-1:0] pin_reg;
  logic [NPIN-1:0] prev_reg;

  assign pin_raw = {chip_select_straps_i, wp_i, sda_i, scl_clk_i};

  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          ff1_reg[i] <= PIN_IDLE[i];
          ff2_reg[i] <= PIN_IDLE[i];
          ff3_reg[i] <= PIN_IDLE[i];
          pin_reg[i] <= PIN_IDLE[i];
          prev_reg[i] <= PIN_IDLE[i];
        end else begin
          ff1_reg[i] <= pin_raw[i];
          ff2_reg[i] <= ff1_reg[i];
          ff3_reg[i] <= ff2_reg[i];
          if (ff2_reg[i] == ff3_reg[i]) begin
            pin_reg[i] <= ff3_reg[i];
          end
          prev_reg[i] <= pin_reg[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  logic scl_f;
  logic sda_f;
  logic scl_p;
  logic sda_p;
  logic wp_f;
  logic [2:0] cs_f;
  logic scl_rise;
  logic scl_fall;
  logic start_e;
  logic stop_e;

  assign scl_f = pin_reg[`SEP_PIN_SCL];
  assign sda_f = pin_reg[`SEP_PIN_SDA];
  assign scl_p = prev_reg[`SEP_PIN_SCL];
  assign sda_p = prev_reg[`SEP_PIN_SDA];
  assign wp_f = pin_reg[`SEP_PIN_WP];
  assign cs_f = pin_reg[`SEP_PIN_CS +: 3];
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign start_e = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_e = scl_f & scl_p & ~sda_p & sda_f;

  // ----------------------------------------
  // Core state
  // ----------------------------------------
  sep_state_t state_reg;
  logic [3:0] cnt_reg;
  logic sda_oe_reg;
  logic sda_o_reg;
  sep_byte_t addr_reg;
  sep_byte_t tx_reg;
  sep_byte_t rd_last_reg;
  logic prot_op_reg;
  logic wr_pend_reg;
  logic flag_reg;
  logic tmr_start_reg;
  logic busy_reg;
  sep_byte_t mem_reg [`SEP_DEPTH];

  // ----------------------------------------
  // Byte decode
  // ----------------------------------------
  sep_byte_t rx;
  logic busy;
  logic byte_end;
  logic ack_end;
  logic arr_code;
  logic prot_code;
  logic dev_ack;
  logic wr_ok;
  logic mem_we;
  logic rd_load;
  logic master_nack;
  sep_byte_t rd_byte;

  assign rx = cif.rx_byte;
  assign busy = cif.tmr_busy;
  assign byte_end = scl_fall & (cnt_reg == `SEP_CNT_ACK);
  assign ack_end = scl_fall & (cnt_reg == `SEP_CNT_END);
  assign arr_code = rx[7:4] == `SEP_CODE_ARRAY;
  assign prot_code = rx[7:4] == `SEP_CODE_PROT;
  assign dev_ack = (rx[3:1] == cs_f) & (arr_code | (prot_code & ~flag_reg));
  assign wr_ok = ~wp_f & ~(flag_reg & (addr_reg <= `SEP_LOW_TOP));
  assign mem_we = byte_end & (state_reg == ST_WDAT) & ~prot_op_reg & wr_ok;
  assign rd_load = ack_end & ((state_reg == ST_RACK) | (state_reg == ST_RDAT));
  assign master_nack = scl_rise & (cnt_reg == `SEP_CNT_ACK) & (state_reg == ST_RDAT) & sda_f;
  assign rd_byte = prot_op_reg ? `SEP_PROT_RD_DATA : mem_reg[addr_reg];

  // ----------------------------------------
  // Transaction sequencer
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else if (busy) begin
      state_reg <= ST_IDLE;
    end else if (start_e) begin
      state_reg <= ST_DEV;
    end else if (stop_e) begin
      state_reg <= ST_IDLE;
    end else if (byte_end) begin
      unique case (state_reg)
        ST_IDLE: state_reg <= ST_IDLE;
        ST_DEV: begin
          if (!dev_ack) begin
            state_reg <= ST_IDLE;
          end else if (rx[0]) begin
            state_reg <= ST_RACK;
          end else begin
            state_reg <= ST_WADR;
          end
        end
        ST_WADR: state_reg <= ST_WDAT;
        ST_WDAT: state_reg <= ST_WDAT;
        ST_RACK: state_reg <= ST_RACK;
        ST_RDAT: state_reg <= ST_RDAT;
      endcase
    end else if (ack_end && state_reg == ST_RACK) begin
      state_reg <= ST_RDAT;
    end else if (master_nack) begin
      state_reg <= ST_IDLE;
    end
  end

  // ----------------------------------------
  // Bit counter
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i || start_e) begin
      cnt_reg <= 4'h0;
    end else if (ack_end) begin
      cnt_reg <= 4'h0;
    end else if (scl_rise && cnt_reg != `SEP_CNT_END) begin
      cnt_reg <= cnt_reg + `SEP_CNT_ONE;
    end
  end

  // ----------------------------------------
  // Data line drive
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i || busy || start_e || stop_e) begin
      sda_oe_reg <= 1'b0;
    end else if (byte_end) begin
      sda_oe_reg <= ((state_reg == ST_DEV) & dev_ack) | (state_reg == ST_WADR) | (state_reg == ST_WDAT);
    end else if (rd_load) begin
      sda_oe_reg <= ~rd_byte[7];
    end else if (ack_end) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall && state_reg == ST_RDAT && cnt_reg != 4'h0) begin
      sda_oe_reg <= ~tx_reg[3'(`SEP_BIT_MSB - cnt_reg)];
    end
  end

  always_ff @(posedge mclk_i) begin
    sda_o_reg <= 1'b0;
  end

  // ----------------------------------------
  // Read data and address counter
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_reg <= 8'h00;
      rd_last_reg <= 8'h00;
    end else if (rd_load) begin
      tx_reg <= rd_byte;
      rd_last_reg <= rd_byte;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      addr_reg <= 8'h00;
    end else if (byte_end && state_reg == ST_WADR && !prot_op_reg) begin
      addr_reg <= rx;
    end else if (byte_end && state_reg == ST_WDAT && !prot_op_reg) begin
      addr_reg <= {addr_reg[7:4], addr_reg[3:0] + 4'h1};
    end else if (rd_load && !prot_op_reg) begin
      addr_reg <= addr_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // Array storage
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (mem_we) begin
      mem_reg[addr_reg] <= rx;
    end
  end

  // ----------------------------------------
  // Write cycle launch and protect flag
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prot_op_reg <= 1'b0;
    end else if (byte_end && state_reg == ST_DEV) begin
      prot_op_reg <= prot_code;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || start_e) begin
      wr_pend_reg <= 1'b0;
    end else if (byte_end && state_reg == ST_WDAT) begin
      wr_pend_reg <= 1'b1;
    end else if (stop_e) begin
      wr_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tmr_start_reg <= 1'b0;
    end else begin
      tmr_start_reg <= stop_e & wr_pend_reg & ~busy;
    end
  end
  assign cif.tmr_start = tmr_start_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flag_reg <= prot_init_i;
    end else if (stop_e && wr_pend_reg && prot_op_reg && !wp_f) begin
      flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy;
    end
  end

  assign rd_last_o = rd_last_reg;
  assign sda_o = sda_o_reg;
  assign sda_oe_o = sda_oe_reg;
  assign prot_flag_o = flag_reg;
  assign busy_o = busy_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sep_byte_t old_byte;
  assign old_byte = mem_reg[addr_reg];

  chk_busy_no_ack: assert property (
    busy |-> !sda_oe_reg
  ) else $error("Line driven during write cycle");

  chk_prot_nack: assert property (
    byte_end && state_reg == ST_DEV && prot_code && flag_reg |=> !sda_oe_reg && state_reg == ST_IDLE
  ) else $error("Protect code acked with flag set");

  chk_cs_mismatch: assert property (
    byte_end && state_reg == ST_DEV && rx[3:1] != cs_f |=> !sda_oe_reg
  ) else $error("Acked wrong select bits");

  chk_arr_read_ack: assert property (
    byte_end && state_reg == ST_DEV && arr_code && rx[0] && rx[3:1] == cs_f |=> sda_oe_reg && state_reg == ST_RACK
  ) else $error("Array read not acked");

  chk_wp_guard: assert property (
    byte_end && state_reg == ST_WDAT && wp_f |=> mem_reg[$past(addr_reg)] == $past(old_byte)
  ) else $error("Write got through protect pin");

  chk_low_half: assert property (
    byte_end && state_reg == ST_WDAT && flag_reg && addr_reg <= `SEP_LOW_TOP |=> mem_reg[$past(addr_reg)] == $past(old_byte)
  ) else $error("Write reached protected half");

  chk_page_wrap: assert property (
    byte_end && state_reg == ST_WDAT && !prot_op_reg |=> addr_reg[7:4] == $past(addr_reg[7:4])
  ) else $error("Write address left its page");

  chk_read_wrap: assert property (
    rd_load && !prot_op_reg && addr_reg == 8'hff |=> addr_reg == 8'h00
  ) else $error("Read counter did not wrap");

  chk_flag_sticky: assert property (
    flag_reg |=> flag_reg
  ) else $error("Protect flag cleared");

  chk_flag_wp: assert property (
    $rose(flag_reg) |-> !$past(wp_f)
  ) else $error("Flag set with pin high");

  chk_timer_start: assert property (
    tmr_start_reg |=> busy ##1 busy
  ) else $error("Write cycle not running after stop");

  cov_page_write: cover property (
    byte_end && state_reg == ST_WDAT && addr_reg[3:0] == 4'hf
  );
  cov_seq_read: cover property (
    rd_load && state_reg == ST_RDAT
  );
  cov_flag_set: cover property (
    $rose(flag_reg)
  );
  cov_poll_nack: cover property (
    busy && start_e
  );
endmodule : sep_eeprom_top

// *** verilog/sep_wr_timer.sv ***
`timescale 1ns/1ns
`include "sep_map.svh"
module sep_wr_timer #(
  parameter int WR_CYCLES = `SEP_TWR_MS * (`SEP_CLK_HZ / `SEP_HZ_PER_MS)
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  sep_core_if.tmr tmr
);
  import sep_pkg::*;
  localparam int CW = $clog2(WR_CYCLES + 1);
  logic [CW-1:0] cnt_reg;
  logic busy_reg;
  // ----------------------------------------
  // Write cycle timer
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (tmr.tmr_start) begin
      cnt_reg <= CW'(WR_CYCLES - 1);
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end
  assign tmr.tmr_busy = busy_reg;
endmodule : sep_wr_timer
